// ===== dv/rft_timer_ctrl_assertions.sv
/*
 Checker of the timer control block: timing relations between its ports.
 Assumes it is bound to rft_timer_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module rft_timer_ctrl_chk (
   input wire logic       I_REF_CLK,
   input wire logic       I_RESET_N,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic       I_WR,
   input wire logic       I_RD,
   input wire logic       I_TX_END,
   input wire logic       I_RX_FIRST_BITS,
   input wire logic       I_LFO,
   input wire logic       I_T1_UNDERFLOW,
   input wire logic       I_T2_UNDERFLOW,
   input wire logic [3:1] I_TIMER_DONE,
   input wire logic [7:0] O_RDATA,
   input wire logic       O_IRQ,
   input wire logic [3:0] O_TIMER_RUN,
   input wire logic       O_T0_UNDERFLOW
);
   // Shadows of config and irq mask, rebuilt from the register writes.
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [7:0] msk_reg;
   logic [7:0] msk_next;
   wire logic  wr_run = I_WR && I_ADDR == 8'h0e;

   always_comb
   begin
      cfg_next = (I_WR && I_ADDR == 8'h0f) ? I_WDATA : cfg_reg;
      msk_next = (I_WR && I_ADDR == 8'h21) ? I_WDATA : msk_reg;
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
      if (!I_RESET_N)
         {cfg_reg, msk_reg} <= 16'h0000;
      else
         {cfg_reg, msk_reg} <= {cfg_next, msk_next};

   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RESET_N);

   AST_RD_RUN: assert property (I_RD && I_ADDR == 8'h0e
      |=> O_RDATA == {$past(O_TIMER_RUN), 4'h0}) else $error("run read wrong");
   AST_MASK_SET: assert property (wr_run |=>
      ((O_TIMER_RUN ^ $past(I_WDATA[7:4])) & $past(I_WDATA[3:0])) == 4'h0)
      else $error("unlocked flag not written");
   AST_MASK_KEEP: assert property (wr_run && I_WDATA[3:1] == 3'h0
      && I_TIMER_DONE == 3'h0 |=> O_TIMER_RUN[3:1] == $past(O_TIMER_RUN[3:1]))
      else $error("locked flag changed");
   AST_DONE_STOP: assert property (I_TIMER_DONE[2]
      && !(wr_run && I_WDATA[2]) |=> !O_TIMER_RUN[2]) else $error("flag kept");
   AST_RX_STOP: assert property (I_RX_FIRST_BITS && cfg_reg[7]
      && !cfg_reg[5] && !wr_run |-> ##[1:2] !O_TIMER_RUN[0]) else $error("no rx stop");
   AST_TX_START: assert property (I_TX_END && cfg_reg[5:4] == 2'h1
      && !wr_run && !I_RX_FIRST_BITS |-> ##[1:2] O_TIMER_RUN[0]) else $error("no start");
   AST_NO_AUTO: assert property (cfg_reg[5:4] == 2'h0 && !wr_run
      && !O_TIMER_RUN[0] |=> !O_TIMER_RUN[0]) else $error("started on its own");
   AST_TRIM_FREE: assert property (cfg_reg[5:4] == 2'h2
      && $past(cfg_reg[5:4]) == 2'h2 |-> !O_T0_UNDERFLOW) else $error("underflow in trim");
   AST_AUTO: assert property (O_T0_UNDERFLOW && cfg_reg[3]
      |-> O_TIMER_RUN[0]) else $error("auto restart lost");
   AST_ONE_SHOT: assert property (O_T0_UNDERFLOW && !cfg_reg[3]
      |-> !O_TIMER_RUN[0]) else $error("one shot kept running");
   AST_IRQ: assert property (O_T0_UNDERFLOW && msk_reg[0]
      |-> O_IRQ) else $error("irq missing");
   AST_CASCADE: assert property (O_T0_UNDERFLOW && cfg_reg[1] |-> (cfg_reg[0]
      ? $past(I_T1_UNDERFLOW) : $past(I_T2_UNDERFLOW))) else $error("bad cascade");

   cover property (O_T0_UNDERFLOW && cfg_reg[3]);
   cover property (O_IRQ);
   cover property (I_RX_FIRST_BITS && O_TIMER_RUN[0]);
endmodule

bind rft_timer_ctrl rft_timer_ctrl_chk i_chk (
   .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WR(I_WR), .I_RD(I_RD), .I_TX_END(I_TX_END), .I_RX_FIRST_BITS(I_RX_FIRST_BITS),
   .I_LFO(I_LFO), .I_T1_UNDERFLOW(I_T1_UNDERFLOW), .I_T2_UNDERFLOW(I_T2_UNDERFLOW),
   .I_TIMER_DONE(I_TIMER_DONE), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
   .O_TIMER_RUN(O_TIMER_RUN), .O_T0_UNDERFLOW(O_T0_UNDERFLOW)
);

`default_nettype wire

// ===== dv/rft_timer_ctrl_tb_top.sv
/*
 Self-checking testbench of the timer control block.
 Assumes the design and its bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module rft_timer_ctrl_tb_top;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       low_freq_oscillator = 1'b0;
   logic [6:0] ev = 7'h00;
   logic [7:0] rdata;
   logic [3:0] run;
   logic       irq;
   logic       uf;
   logic [7:0] uf_count = 8'h00;
   int         failures = 0;
   int         tests_run = 0;
   int         cycles = 0;

   always #4 clk = ~clk;

   // Event pulses share one vector: tx end, rx, t1, t2, then done[3:1].
   rft_timer_ctrl i_dut (
      .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .I_TX_END(ev[0]), .I_RX_FIRST_BITS(ev[1]),
      .I_LFO(low_freq_oscillator), .I_T1_UNDERFLOW(ev[2]), .I_T2_UNDERFLOW(ev[3]),
      .I_TIMER_DONE(ev[6:4]), .O_RDATA(rdata), .O_IRQ(irq),
      .O_TIMER_RUN(run), .O_T0_UNDERFLOW(uf)
   );

   task automatic report_and_stop();
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // The underflow pulse stands one cycle, so it is counted mid-cycle where it is settled.
   always @(negedge clk)
   begin
      if (uf === 1'b1)
         uf_count <= uf_count + 8'h01;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk($sformatf("register %h", a), e, rdata);
   endtask

   task automatic pulse(input logic [6:0] v, input int n);
      repeat (n)
      begin
         @(posedge clk);
         ev <= v;
         @(posedge clk);
         ev <= 7'h00;
      end
   endtask

   // Two edges of slack let registered flags settle before the look.
   task automatic flags(input logic [3:0] e);
      repeat (2) @(posedge clk);
      #1 chk("run flags", {4'h0, e}, {4'h0, run});
   endtask

   task automatic t_regs();
      rdc(8'h0e, 8'h00);
      wrr(8'h0f, 8'hff);
      rdc(8'h0f, 8'hbb);
      rdc(8'h30, 8'h00);
      wrr(8'h0f, 8'h03);
   endtask

   task automatic t_mask();
      wrr(8'h0e, 8'hf0);
      rdc(8'h0e, 8'h00);
      wrr(8'h0e, 8'hff);
      rdc(8'h0e, 8'hf0);
      wrr(8'h0e, 8'h0a);
      rdc(8'h0e, 8'h50);
      pulse(7'h20, 1);
      flags(4'h1);
      wrr(8'h0e, 8'h01);
      flags(4'h0);
   endtask

   task automatic t_cascade();
      wrr(8'h11, 8'h02);
      wrr(8'h21, 8'h01);
      wrr(8'h0e, 8'h11);
      // Count bytes are read only while no frame is being received.
      rdc(8'h13, 8'h02);
      wrr(8'h11, 8'h09);
      rdc(8'h13, 8'h02);
      pulse(7'h04, 2);
      rdc(8'h13, 8'h00);
      pulse(7'h04, 1);
      flags(4'h0);
      chk("underflow count", 8'h01, uf_count);
      chk("irq", 8'h01, {7'h00, irq});
      rdc(8'h20, 8'h03);
      wrr(8'h20, 8'h03);
      rdc(8'h20, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      wrr(8'h21, 8'h00);
      wrr(8'h0f, 8'h0a);
      wrr(8'h0e, 8'h11);
      pulse(7'h04, 1);
      rdc(8'h13, 8'h09);
      pulse(7'h08, 10);
      flags(4'h1);
      chk("underflow count", 8'h02, uf_count);
      rdc(8'h13, 8'h09);
      rdc(8'h20, 8'h01);
      chk("irq", 8'h00, {7'h00, irq});
      wrr(8'h0e, 8'h01);
   endtask

   task automatic t_events();
      wrr(8'h0f, 8'h13);
      pulse(7'h01, 1);
      flags(4'h1);
      wrr(8'h0f, 8'h93);
      pulse(7'h02, 1);
      flags(4'h0);
      wrr(8'h0f, 8'h03);
      pulse(7'h01, 1);
      flags(4'h0);
      wrr(8'h0f, 8'h23);
      wrr(8'h0f, 8'hb3);
      low_freq_oscillator <= 1'b1;
      repeat (4) @(posedge clk);
      flags(4'h1);
      pulse(7'h02, 1);
      flags(4'h1);
      low_freq_oscillator <= 1'b0;
      repeat (6) @(posedge clk);
      low_freq_oscillator <= 1'b1;
      repeat (4) @(posedge clk);
      flags(4'h0);
      // Trimming without underflow: the count parks at zero and keeps running.
      wrr(8'h0f, 8'h23);
      low_freq_oscillator <= 1'b0;
      repeat (6) @(posedge clk);
      low_freq_oscillator <= 1'b1;
      repeat (4) @(posedge clk);
      flags(4'h1);
      pulse(7'h04, 10);
      rdc(8'h13, 8'h00);
      flags(4'h1);
      chk("underflow count", 8'h02, uf_count);
      wrr(8'h0e, 8'h01);
   endtask

   // The rate enables run free, so each window allows one tick of phase.
   task automatic t_clocks();
      wrr(8'h0f, 8'h00);
      wrr(8'h11, 8'h10);
      wrr(8'h0e, 8'h11);
      repeat (100) @(posedge clk);
      flags(4'h1);
      repeat (100) @(posedge clk);
      flags(4'h0);
      wrr(8'h0f, 8'h01);
      wrr(8'h11, 8'h02);
      wrr(8'h0e, 8'h11);
      repeat (1140) @(posedge clk);
      flags(4'h1);
      repeat (700) @(posedge clk);
      flags(4'h0);
      chk("underflow count", 8'h04, uf_count);
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_mask();
      t_cascade();
      t_events();
      t_clocks();
      report_and_stop();
   end
endmodule

`default_nettype wire

// ===== hw/rft_map.svh
/*
 Register offsets, field positions, reset values and clock rates of the
 timer control block. Definitions only; included by the timer control module alone.
*/
`ifndef RFT_MAP_SVH
`define RFT_MAP_SVH

`define RFT_ADDR_RUN       8'h0e
`define RFT_ADDR_CFG       8'h0f
`define RFT_ADDR_RLD_HI    8'h10
`define RFT_ADDR_RLD_LO    8'h11
`define RFT_ADDR_CNT_HI    8'h12
`define RFT_ADDR_CNT_LO    8'h13
`define RFT_ADDR_IRQ_STAT  8'h20
`define RFT_ADDR_IRQ_MASK  8'h21

`define RFT_RUN_FLAG_LSB   4
`define RFT_CFG_HALT_RX    7
`define RFT_CFG_MODE_HI    5
`define RFT_CFG_MODE_LO    4
`define RFT_CFG_AUTO       3
`define RFT_CFG_CLK_HI     1
`define RFT_CFG_CLK_LO     0
`define RFT_CFG_WMASK      8'hbb
`define RFT_CFG_RESET      8'h00
`define RFT_RLD_RESET      8'h00
`define RFT_CNT_RESET      16'h0000
`define RFT_IRQ_UNDERFLOW  0
`define RFT_IRQ_HW_STOP    1
`define RFT_IRQ_RESET      2'h0
`define RFT_RDATA_ZERO     8'h00

`define RFT_CLK_HZ         125000000
`define RFT_FAST_HZ        13560000
`define RFT_SLOW_HZ        211875

`endif

// ===== hw/rft_pkg.sv
/*
 Types shared by the timer control block: timer 0 state, start modes and
 count clock selections. Assumes nothing of its surroundings.
*/
package rft_pkg;

   typedef enum logic [1:0]
   {
      T0_IDLE  = 2'b01,
      T0_COUNT = 2'b10
   } rft_t0_state_t;

   typedef enum logic [1:0]
   {
      START_NONE      = 2'h0,
      START_TX_END    = 2'h1,
      START_TRIM_FREE = 2'h2,
      START_TRIM_UF   = 2'h3
   } rft_start_mode_t;

   typedef enum logic [1:0]
   {
      CLK_FAST   = 2'h0,
      CLK_SLOW   = 2'h1,
      CLK_T2_UF  = 2'h2,
      CLK_T1_UF  = 2'h3
   } rft_clk_sel_t;

endpackage

// ===== hw/rft_rate_gen.sv
/*
 Fractional rate generator: a phase accumulator that emits a one-cycle enable
 at an average rate of INC / 2**ACC_W of the clock. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module rft_rate_gen #(
   parameter int               ACC_W = 24,
   parameter logic [ACC_W-1:0] INC   = '0
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   output var  logic o_en
);

   // Enables jitter by one clock period; only the average rate is exact.
   logic [ACC_W-1:0] acc_reg;
   logic [ACC_W-1:0] acc_next;
   logic             en_next;

   always_comb
   begin
      {en_next, acc_next} = {1'b0, acc_reg} + {1'b0, INC};
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         acc_reg <= '0;
         o_en    <= 1'b0;
      end
      else
      begin
         acc_reg <= acc_next;
         o_en    <= en_next;
      end
   end

endmodule

`default_nettype wire

// ===== hw/rft_sync.sv
/*
 Two flip-flop synchroniser for levels that arrive from outside the clock
 domain. Assumes the inputs are levels held for at least two clock periods.
*/
`timescale 1ns/1ps
`default_nettype none

module rft_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_async,
   output var  logic [W-1:0] o_sync
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_next;

   always_comb
   begin
      meta_next = i_async;
      sync_next = meta_reg;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_reg <= '0;
         o_sync   <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         o_sync   <= sync_next;
      end
   end

endmodule

`default_nettype wire

// ===== hw/rft_timer_ctrl.sv
/*
 Timer control block: the shared run control register of four timers and the
 full count logic of timer 0, with reload, auto-restart, stop on receive,
 oscillator trimming, clock selection and an underflow interrupt.
 Assumes a register master on the same clock, receiver and transmitter events
 as one-cycle pulses on the same clock, and underflow pulses from timers 1
 and 2. The low-frequency oscillator arrives on a pin and is synchronised.
*/

`timescale 1ns/1ps
`default_nettype none

`include "rft_map.svh"

module rft_timer_ctrl #(
   parameter int ACC_W = 24
) (
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RESET_N,
   input  wire logic [7:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   input  wire logic       I_TX_END,
   input  wire logic       I_RX_FIRST_BITS,
   input  wire logic       I_LFO,
   input  wire logic       I_T1_UNDERFLOW,
   input  wire logic       I_T2_UNDERFLOW,
   input  wire logic [3:1] I_TIMER_DONE,
   output var  logic [7:0] O_RDATA,
   output var  logic       O_IRQ,
   output var  logic [3:0] O_TIMER_RUN,
   output var  logic       O_T0_UNDERFLOW
);

   localparam longint unsigned FAST_INC_L =
      (longint'(`RFT_FAST_HZ) << ACC_W) / longint'(`RFT_CLK_HZ);
   localparam longint unsigned SLOW_INC_L =
      (longint'(`RFT_SLOW_HZ) << ACC_W) / longint'(`RFT_CLK_HZ);
   localparam logic [ACC_W-1:0] FAST_INC = FAST_INC_L[ACC_W-1:0];
   localparam logic [ACC_W-1:0] SLOW_INC = SLOW_INC_L[ACC_W-1:0];

   logic fast_en;
   logic slow_en;
   logic lfo_sync;

   rft_rate_gen #(
      .ACC_W (ACC_W),
      .INC   (FAST_INC)
   ) u_fast (
      .i_clk   (I_REF_CLK),
      .i_rst_n (I_RESET_N),
      .o_en    (fast_en)
   );

   rft_rate_gen #(
      .ACC_W (ACC_W),
      .INC   (SLOW_INC)
   ) u_slow (
      .i_clk   (I_REF_CLK),
      .i_rst_n (I_RESET_N),
      .o_en    (slow_en)
   );

   rft_sync #(
      .W (1)
   ) u_lfo_sync (
      .i_clk   (I_REF_CLK),
      .i_rst_n (I_RESET_N),
      .i_async (I_LFO),
      .o_sync  (lfo_sync)
   );

   // Register state.
   rft_pkg::rft_t0_state_t t0_state_reg;
   rft_pkg::rft_t0_state_t t0_state_next;
   logic [15:0]            count_reg;
   logic [15:0]            count_next;
   logic [3:1]             run_reg;
   logic [3:1]             run_next;
   logic [7:0]             cfg_reg;
   logic [7:0]             cfg_next;
   logic [7:0]             rld_hi_reg;
   logic [7:0]             rld_hi_next;
   logic [7:0]             rld_lo_reg;
   logic [7:0]             rld_lo_next;
   logic [1:0]             stat_reg;
   logic [1:0]             stat_next;
   logic [1:0]             mask_reg;
   logic [1:0]             mask_next;
   logic                   lfo_prev_reg;
   logic [7:0]             rdata_next;
   logic                   irq_next;
   logic                   uf_next;
   logic [3:0]             run_out_next;

   // Decoded controls and timer 0 events.
   rft_pkg::rft_start_mode_t mode;
   rft_pkg::rft_clk_sel_t    clk_sel;
   logic                     trim;
   logic                     tick;
   logic                     lfo_rise;
   logic                     start_ev;
   logic                     stop_ev;
   logic                     hw_stop;
   logic                     run_wr;

   always_comb
   begin
      mode     = rft_pkg::rft_start_mode_t'(cfg_reg[`RFT_CFG_MODE_HI:`RFT_CFG_MODE_LO]);
      clk_sel  = rft_pkg::rft_clk_sel_t'(cfg_reg[`RFT_CFG_CLK_HI:`RFT_CFG_CLK_LO]);
      trim     = (mode == rft_pkg::START_TRIM_FREE) || (mode == rft_pkg::START_TRIM_UF);
      lfo_rise = lfo_sync && !lfo_prev_reg;
      run_wr   = I_WR && (I_ADDR == `RFT_ADDR_RUN);

      unique case (clk_sel)
         rft_pkg::CLK_FAST:  tick = fast_en;
         rft_pkg::CLK_SLOW:  tick = slow_en;
         rft_pkg::CLK_T2_UF: tick = I_T2_UNDERFLOW;
         rft_pkg::CLK_T1_UF: tick = I_T1_UNDERFLOW;
      endcase

      cfg_next    = cfg_reg;
      rld_hi_next = rld_hi_reg;
      rld_lo_next = rld_lo_reg;
      mask_next   = mask_reg;
      if (I_WR)
      begin
         unique case (I_ADDR)
            `RFT_ADDR_CFG:      cfg_next = I_WDATA & `RFT_CFG_WMASK;
            `RFT_ADDR_RLD_HI:   rld_hi_next = I_WDATA;
            `RFT_ADDR_RLD_LO:   rld_lo_next = I_WDATA;
            `RFT_ADDR_IRQ_MASK: mask_next = I_WDATA[1:0];
            default:            cfg_next = cfg_reg;
         endcase
      end

      // Timer 0 count and automatic events.
      start_ev   = 1'b0;
      stop_ev    = 1'b0;
      hw_stop    = 1'b0;
      uf_next    = 1'b0;
      count_next = count_reg;
      if ((t0_state_reg == rft_pkg::T0_COUNT) && tick)
      begin
         if (count_reg == 16'h0000)
         begin
            // Trimming without underflow simply parks the count at zero.
            if (mode != rft_pkg::START_TRIM_FREE)
            begin
               uf_next = 1'b1;
               if (cfg_reg[`RFT_CFG_AUTO])
                  count_next = {rld_hi_reg, rld_lo_reg};
               else
                  hw_stop = 1'b1;
            end
         end
         else
         begin
            count_next = count_reg - 16'h0001;
         end
      end

      if (cfg_reg[`RFT_CFG_HALT_RX] && !trim && I_RX_FIRST_BITS &&
          (t0_state_reg == rft_pkg::T0_COUNT))
         hw_stop = 1'b1;

      if ((mode == rft_pkg::START_TX_END) && I_TX_END &&
          (t0_state_reg == rft_pkg::T0_IDLE))
         start_ev = 1'b1;

      if (trim && lfo_rise)
      begin
         if (t0_state_reg == rft_pkg::T0_IDLE)
            start_ev = 1'b1;
         else
            hw_stop = 1'b1;
      end

      stop_ev = hw_stop;
      // A software start or stop overrides any automatic event of the cycle.
      if (run_wr && I_WDATA[0])
      begin
         start_ev = I_WDATA[`RFT_RUN_FLAG_LSB];
         stop_ev  = !I_WDATA[`RFT_RUN_FLAG_LSB];
      end

      t0_state_next = t0_state_reg;
      if (stop_ev)
      begin
         t0_state_next = rft_pkg::T0_IDLE;
      end
      else if (start_ev)
      begin
         t0_state_next = rft_pkg::T0_COUNT;
         count_next    = {rld_hi_reg, rld_lo_reg};
      end

      // Running flags of timers 1 to 3; a masked write beats a done pulse.
      for (int i = 1; i < 4; i++)
      begin
         run_next[i] = run_reg[i];
         if (run_wr && I_WDATA[i])
            run_next[i] = I_WDATA[i + `RFT_RUN_FLAG_LSB];
         else if (I_TIMER_DONE[i])
            run_next[i] = 1'b0;
      end

      // Sticky status: a new event wins over a same-cycle write-one clear.
      stat_next = stat_reg;
      if (I_WR && (I_ADDR == `RFT_ADDR_IRQ_STAT))
         stat_next = stat_reg & ~I_WDATA[1:0];
      if (uf_next)
         stat_next[`RFT_IRQ_UNDERFLOW] = 1'b1;
      if (hw_stop)
         stat_next[`RFT_IRQ_HW_STOP] = 1'b1;
      irq_next = |(stat_next & mask_next);

      run_out_next = {run_next, t0_state_next == rft_pkg::T0_COUNT};

      rdata_next = `RFT_RDATA_ZERO;
      if (I_RD)
      begin
         unique case (I_ADDR)
            `RFT_ADDR_RUN:
               rdata_next = {run_reg, t0_state_reg == rft_pkg::T0_COUNT, 4'h0};
            `RFT_ADDR_CFG:      rdata_next = cfg_reg;
            `RFT_ADDR_RLD_HI:   rdata_next = rld_hi_reg;
            `RFT_ADDR_RLD_LO:   rdata_next = rld_lo_reg;
            // The count is live; reading it during reception is not coherent.
            `RFT_ADDR_CNT_HI:   rdata_next = count_reg[15:8];
            `RFT_ADDR_CNT_LO:   rdata_next = count_reg[7:0];
            `RFT_ADDR_IRQ_STAT: rdata_next = {6'h00, stat_reg};
            `RFT_ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
            default:            rdata_next = `RFT_RDATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         t0_state_reg   <= rft_pkg::T0_IDLE;
         count_reg      <= `RFT_CNT_RESET;
         run_reg        <= 3'h0;
         cfg_reg        <= `RFT_CFG_RESET;
         rld_hi_reg     <= `RFT_RLD_RESET;
         rld_lo_reg     <= `RFT_RLD_RESET;
         stat_reg       <= `RFT_IRQ_RESET;
         mask_reg       <= `RFT_IRQ_RESET;
         lfo_prev_reg   <= 1'b0;
         O_RDATA        <= `RFT_RDATA_ZERO;
         O_IRQ          <= 1'b0;
         O_TIMER_RUN    <= 4'h0;
         O_T0_UNDERFLOW <= 1'b0;
      end
      else
      begin
         t0_state_reg   <= t0_state_next;
         count_reg      <= count_next;
         run_reg        <= run_next;
         cfg_reg        <= cfg_next;
         rld_hi_reg     <= rld_hi_next;
         rld_lo_reg     <= rld_lo_next;
         stat_reg       <= stat_next;
         mask_reg       <= mask_next;
         lfo_prev_reg   <= lfo_sync;
         O_RDATA        <= rdata_next;
         O_IRQ          <= irq_next;
         O_TIMER_RUN    <= run_out_next;
         O_T0_UNDERFLOW <= uf_next;
      end
   end

endmodule

`default_nettype wire
